// *** cssfc_consts.vh ***
// constants for the core stall and flush control block
`ifndef CSSFC_CONSTS_VH
`define CSSFC_CONSTS_VH

// ************************************************************
// register offsets (byte addresses on the plain register port)
// ************************************************************
`define CSSFC_OFF_CTRL 8'h00
`define CSSFC_OFF_STATUS 8'h04
`define CSSFC_OFF_STALL_TOTAL 8'h08
`define CSSFC_OFF_FLUSH_TOTAL 8'h0c

// ************************************************************
// field positions and reset values
// ************************************************************
`define CSSFC_CTRL_PRED_EN 0
`define CSSFC_CTRL_CLR_CNT 1
`define CSSFC_CTRL_RESET 1'h0
`define CSSFC_ST_STALLING 0
`define CSSFC_ST_FLUSHING 1
`define CSSFC_ST_STALL_LSB 8
`define CSSFC_ST_FLUSH_LSB 16

// ************************************************************
// history word layout (one word per issued instruction)
// ************************************************************
`define CSSFC_H_LD_UNC 0
`define CSSFC_H_LD_COND 1
`define CSSFC_H_SEXT 2
`define CSSFC_H_PM_COND 3
`define CSSFC_H_COND_SET 4
`define CSSFC_H_COND_ASTAT 5
`define CSSFC_H_FRAME 6
`define CSSFC_H_CURRENT_LOOP_COUNT 7
`define CSSFC_H_LSTK 8
`define CSSFC_H_SYSREG 9
`define CSSFC_H_IDX_LSB 10
`define CSSFC_H_IDX_MSB 13
`define CSSFC_H_W 14

// ************************************************************
// stall and flush cycle counts
// ************************************************************
`define CSSFC_CNT_W 5
`define CSSFC_N_ZERO 5'h00
`define CSSFC_N_ONE 5'h01
`define CSSFC_N_LOAD_UNC 5'h04
`define CSSFC_N_LOAD_COND 5'h05
`define CSSFC_N_POSTMOD 5'h05
`define CSSFC_N_IMM_LOAD 5'h00
`define CSSFC_N_FRAME 5'h06
`define CSSFC_N_LOOP_GAP 5'h04
`define CSSFC_N_LOOP_ABORT 5'h04
`define CSSFC_N_TGT_RET 5'h03
`define CSSFC_N_TGT_JUMP 5'h01
`define CSSFC_N_LSTK 5'h05
`define CSSFC_N_SYSREG 5'h05
`define CSSFC_N_CURRENT_LOOP_COUNT 5'h01
`define CSSFC_F_BR_UNC 5'h06
`define CSSFC_F_BR_COND 5'h0b
`define CSSFC_F_DELAY_SLOT 5'h02
`define CSSFC_F_INT_RET 5'h07
`define CSSFC_F_LOOP_TERM 5'h0b

`endif

// *** cssfc_history.v ***
// two-deep history of the attributes of recently issued instructions
`timescale 1ns/1ps
`include "cssfc_consts.vh"

module cssfc_history (
  input wire clk_sys,
  input wire rst_n,
  input wire shift_en,
  input wire clear,
  input wire [`CSSFC_H_W-1:0] cur_word,
  output reg [`CSSFC_H_W-1:0] prev1,
  output reg [`CSSFC_H_W-1:0] prev2
);

  // ************************************************************
  // shift on each real issue; a flush empties it so that
  // cancelled instructions leave no hazard behind
  // ************************************************************
  always @(posedge clk_sys) begin
    if (!rst_n || clear) begin
      prev1 <= {`CSSFC_H_W{1'b0}};
      prev2 <= {`CSSFC_H_W{1'b0}};
    end else if (shift_en) begin
      prev1 <= cur_word;
      prev2 <= prev1;
    end
  end

endmodule // cssfc_history

// *** cssfc_core.v ***
// stall and flush control for the deep core pipeline, with its register port
//
// The implementer's own choices: the strobed register port and the register addresses.
`timescale 1ns/1ps
`include "cssfc_consts.vh"

//
// Behaviour
// - unconditional index load then use: four stalls
// - conditional load after condition set: five stalls
// - set, conditional post-modify, same index: five stalls
// - immediate index load then use: no stall
// - sign-extended dependent load adds one stall
// - condition from arith status write adds one
// - unconditional branch miss flushes six, delayed four
// - just-set conditional branch miss: eleven, delayed nine
// - delayed branch flushes two fewer instructions
// - interrupt return miss flushes seven cycles, delayed or not
// - frame op then frame index use: six stalls
// - index load to indirect jump: four/five stalls
// - loop termination flushes eleven cycles
// - loop counter write then expiry test: one
// - start of short hardware loop: no stall
// - change of flow at N in unrolled: 4-N
// - return N before loop end: 4-N stalls
// - jump with loop abort adds four stalls
// - call/return target is a return: three
// - call/return target is a jump: one
// - loop stack change then return/jump: five
// - system register update to N+2: five
module cssfc_core (
  input wire clk_sys,
  input wire rst_n,
  // register port
  input wire [7:0] reg_addr,
  input wire [31:0] reg_wdata,
  input wire reg_wr,
  input wire reg_rd,
  output reg [31:0] reg_rdata,
  // instruction presented at the issue stage
  input wire iss_valid,
  input wire iss_dag_load,
  input wire iss_dag_load_cond,
  input wire iss_dag_load_imm,
  input wire iss_sign_ext,
  input wire iss_postmod_cond,
  input wire [3:0] iss_dest_idx,
  input wire iss_cond_set,
  input wire iss_cond_astat,
  input wire iss_agen_use,
  input wire iss_ind_jump,
  input wire [3:0] iss_use_idx,
  input wire iss_branch,
  input wire iss_branch_cond,
  input wire iss_delayed,
  input wire iss_int_return,
  input wire iss_sub_return,
  input wire iss_jump,
  input wire iss_loop_abort,
  input wire btb_hit,
  input wire iss_frame_op,
  input wire iss_use_fi6,
  input wire iss_read_fi67,
  input wire iss_current_loop_count_write,
  input wire iss_lce_cond,
  input wire iss_loop_start,
  input wire iss_cof_unrolled,
  input wire [1:0] iss_cof_pos,
  input wire iss_ret_loop_end,
  input wire [1:0] iss_ret_dist,
  input wire iss_target_is_ret,
  input wire iss_target_is_jump,
  input wire iss_lstk_mod,
  input wire iss_sysreg_update,
  input wire iss_second_pe_only,
  input wire iss_mode_dep,
  input wire loop_term,
  // pipeline control
  output wire stall,
  output wire issue,
  output wire flush
);

  // ************************************************************
  // helpers
  // ************************************************************
  function [`CSSFC_CNT_W-1:0] f_max;
    input [`CSSFC_CNT_W-1:0] a;
    input [`CSSFC_CNT_W-1:0] b;
    begin
      f_max = (a > b) ? a : b;
    end
  endfunction

  // stall for a position 0..3 ahead of a loop boundary
  function [`CSSFC_CNT_W-1:0] f_loop_gap;
    input [1:0] n;
    begin
      f_loop_gap = `CSSFC_N_LOOP_GAP - {3'h0, n};
    end
  endfunction

  // ************************************************************
  // state
  // ************************************************************
  reg pred_en;
  reg [`CSSFC_CNT_W-1:0] stall_cnt;
  reg [`CSSFC_CNT_W-1:0] flush_cnt;
  reg evaluated;
  reg [31:0] stall_total;
  reg [31:0] flush_total;
  wire [`CSSFC_H_W-1:0] prev1;
  wire [`CSSFC_H_W-1:0] prev2;
  wire [`CSSFC_H_W-1:0] cur_word;
  wire [3:0] p1_idx;
  wire busy;
  wire flushing;
  wire fresh;
  wire agen_match;
  wire jump_match;
  wire miss;
  reg [`CSSFC_CNT_W-1:0] data_need;
  reg [`CSSFC_CNT_W-1:0] stall_need;
  reg [`CSSFC_CNT_W-1:0] br_flush;
  reg [`CSSFC_CNT_W-1:0] next_flush_cnt;
  reg [`CSSFC_CNT_W-1:0] next_stall_cnt;

  // ************************************************************
  // history of issued instructions
  // ************************************************************
  // the pe-only mode bit change never marks a system register hazard
  assign cur_word = {iss_dest_idx,
                     iss_sysreg_update & ~iss_second_pe_only,
                     iss_lstk_mod,
                     iss_current_loop_count_write,
                     iss_frame_op,
                     iss_cond_astat,
                     iss_cond_set,
                     iss_postmod_cond,
                     iss_sign_ext,
                     iss_dag_load & iss_dag_load_cond & ~iss_dag_load_imm,
                     iss_dag_load & ~iss_dag_load_cond & ~iss_dag_load_imm};

  cssfc_history u_hist (
    .clk_sys(clk_sys),
    .rst_n(rst_n),
    .shift_en(issue),
    .clear(flush),
    .cur_word(cur_word),
    .prev1(prev1),
    .prev2(prev2)
  );

  // only the index field of the newest entry is compared; the older
  // entry feeds the condition and system register checks alone
  assign p1_idx = prev1[`CSSFC_H_IDX_MSB:`CSSFC_H_IDX_LSB];
  assign agen_match = iss_agen_use & (iss_use_idx == p1_idx);
  assign jump_match = iss_ind_jump & (iss_use_idx == p1_idx);

  // ************************************************************
  // stall demand of the instruction at the issue stage
  // ************************************************************
  // the largest single hazard wins; loop abort stacks on top
  always @* begin
    data_need = `CSSFC_N_ZERO;
    if (prev1[`CSSFC_H_LD_UNC] && (agen_match || jump_match)) begin
      data_need = `CSSFC_N_LOAD_UNC + {4'h0, prev1[`CSSFC_H_SEXT]};
    end
    // a conditional load with no condition set just before it costs
    // the same as an unconditional one
    if (prev1[`CSSFC_H_LD_COND] && (agen_match || jump_match)) begin
      if (prev2[`CSSFC_H_COND_SET]) begin
        data_need = `CSSFC_N_LOAD_COND + {4'h0, prev2[`CSSFC_H_COND_ASTAT]} +
                    {4'h0, prev1[`CSSFC_H_SEXT]};
      end else begin
        data_need = `CSSFC_N_LOAD_UNC + {4'h0, prev1[`CSSFC_H_SEXT]};
      end
    end
    if (prev1[`CSSFC_H_PM_COND] && prev2[`CSSFC_H_COND_SET] &&
        (agen_match || jump_match)) begin
      data_need = f_max(data_need,
                        `CSSFC_N_POSTMOD + {4'h0, prev2[`CSSFC_H_COND_ASTAT]});
    end
  end

  always @* begin
    stall_need = data_need;
    // frame stalls are separate from any branch flush and add in time
    if (prev1[`CSSFC_H_FRAME] && (iss_use_fi6 || iss_read_fi67)) begin
      stall_need = f_max(stall_need, `CSSFC_N_FRAME);
    end
    if (prev1[`CSSFC_H_CURRENT_LOOP_COUNT] && iss_lce_cond) begin
      stall_need = f_max(stall_need, `CSSFC_N_CURRENT_LOOP_COUNT);
    end
    if (iss_cof_unrolled) begin
      stall_need = f_max(stall_need, f_loop_gap(iss_cof_pos));
    end
    if (iss_ret_loop_end && (iss_sub_return || iss_int_return)) begin
      stall_need = f_max(stall_need, f_loop_gap(iss_ret_dist));
    end
    if (iss_target_is_ret) begin
      stall_need = f_max(stall_need, `CSSFC_N_TGT_RET);
    end
    if (iss_target_is_jump) begin
      stall_need = f_max(stall_need, `CSSFC_N_TGT_JUMP);
    end
    if (prev1[`CSSFC_H_LSTK] && (iss_sub_return || iss_int_return || iss_jump)) begin
      stall_need = f_max(stall_need, `CSSFC_N_LSTK);
    end
    if (prev2[`CSSFC_H_SYSREG] && iss_mode_dep) begin
      stall_need = f_max(stall_need, `CSSFC_N_SYSREG);
    end
    // a loop start adds nothing by itself, whatever its body length
    if (iss_loop_start) begin
      stall_need = stall_need + `CSSFC_N_ZERO;
    end
    if (iss_loop_abort && iss_jump) begin
      stall_need = stall_need + `CSSFC_N_LOOP_ABORT;
    end
  end

  // ************************************************************
  // flush demand of a branch leaving the issue stage
  // ************************************************************
  // a predicted branch is resolved elsewhere and costs nothing here
  assign miss = ~pred_en | ~btb_hit;

  always @* begin
    br_flush = `CSSFC_N_ZERO;
    // an interrupt return ignores the delay slot modifier entirely
    if (iss_int_return) begin
      br_flush = `CSSFC_F_INT_RET;
    end else if (iss_branch && iss_branch_cond && prev1[`CSSFC_H_COND_SET]) begin
      br_flush = `CSSFC_F_BR_COND + {4'h0, prev1[`CSSFC_H_COND_ASTAT]};
    end else if (iss_branch) begin
      br_flush = `CSSFC_F_BR_UNC;
    end
    // delay slot instructions survive, so two fewer are cancelled
    if (iss_delayed && !iss_int_return && br_flush != `CSSFC_N_ZERO) begin
      br_flush = br_flush - `CSSFC_F_DELAY_SLOT;
    end
    if (!miss) begin
      br_flush = `CSSFC_N_ZERO;
    end
  end

  // ************************************************************
  // handshake towards the sequencer
  // ************************************************************
  // an instruction is judged once; while held the stages behind
  // it keep moving, the issue stage and earlier ones wait
  // limitation: upstream must hold every iss_* input steady while
  // stall is high, or the judgement taken in the first cycle is stale
  assign busy = (stall_cnt != `CSSFC_N_ZERO);
  assign flushing = (flush_cnt != `CSSFC_N_ZERO);
  assign flush = flushing;
  assign fresh = iss_valid & ~busy & ~evaluated & ~flushing;
  assign stall = busy | (fresh & (stall_need != `CSSFC_N_ZERO));
  assign issue = iss_valid & ~stall & ~flushing;

  always @* begin
    next_stall_cnt = stall_cnt;
    // a loop end cancels the held instruction too, so the stall is
    // dropped at once and never overlaps the flush that follows
    if (flushing || loop_term) begin
      next_stall_cnt = `CSSFC_N_ZERO;
    end else if (fresh && stall_need != `CSSFC_N_ZERO) begin
      next_stall_cnt = stall_need - `CSSFC_N_ONE;
    end else if (busy) begin
      next_stall_cnt = stall_cnt - `CSSFC_N_ONE;
    end
  end

  // loop termination and a missed branch may coincide; the longer wins
  always @* begin
    next_flush_cnt = flushing ? (flush_cnt - `CSSFC_N_ONE) : `CSSFC_N_ZERO;
    if (issue) begin
      next_flush_cnt = f_max(next_flush_cnt, br_flush);
    end
    if (loop_term) begin
      next_flush_cnt = f_max(next_flush_cnt, `CSSFC_F_LOOP_TERM);
    end
  end

  // ************************************************************
  // counters and judgement flag
  // ************************************************************
  // the flag keeps a held instruction from being judged twice
  always @(posedge clk_sys) begin
    if (!rst_n) begin
      stall_cnt <= `CSSFC_N_ZERO;
      flush_cnt <= `CSSFC_N_ZERO;
      evaluated <= 1'b0;
    end else begin
      stall_cnt <= next_stall_cnt;
      flush_cnt <= next_flush_cnt;
      if (issue || flushing || !iss_valid) begin
        evaluated <= 1'b0;
      end else if (fresh) begin
        evaluated <= 1'b1;
      end
    end
  end

  // ************************************************************
  // register port
  // ************************************************************
  // clearing the totals in a busy cycle keeps that cycle's count
  always @(posedge clk_sys) begin
    if (!rst_n) begin
      pred_en <= `CSSFC_CTRL_RESET;
      stall_total <= 32'h00000000;
      flush_total <= 32'h00000000;
    end else begin
      if (reg_wr && reg_addr == `CSSFC_OFF_CTRL) begin
        pred_en <= reg_wdata[`CSSFC_CTRL_PRED_EN];
      end
      if (reg_wr && reg_addr == `CSSFC_OFF_CTRL && reg_wdata[`CSSFC_CTRL_CLR_CNT]) begin
        stall_total <= {31'h00000000, stall};
        flush_total <= {31'h00000000, flushing};
      end else begin
        stall_total <= stall_total + {31'h00000000, stall};
        flush_total <= flush_total + {31'h00000000, flushing};
      end
    end
  end

  // read data stand in the cycle after the strobe only
  always @(posedge clk_sys) begin
    if (!rst_n) begin
      reg_rdata <= 32'h00000000;
    end else if (reg_rd) begin
      // unmapped offsets read as zero
      case (reg_addr)
        `CSSFC_OFF_CTRL: reg_rdata <= {31'h00000000, pred_en};
        `CSSFC_OFF_STATUS: reg_rdata <= {11'h000, flush_cnt, 3'h0, stall_cnt,
                                         6'h00, flushing, busy};
        `CSSFC_OFF_STALL_TOTAL: reg_rdata <= stall_total;
        `CSSFC_OFF_FLUSH_TOTAL: reg_rdata <= flush_total;
        default: reg_rdata <= 32'h00000000;
      endcase
    end else begin
      reg_rdata <= 32'h00000000;
    end
  end

endmodule // cssfc_core

// *** cssfc_checker.sv ***
// concurrent checks on the ports of the stall and flush control block
`timescale 1ns/1ps
module cssfc_checker (
  input wire clk_sys,
  input wire rst_n,
  input wire iss_valid,
  input wire iss_dag_load,
  input wire iss_dag_load_cond,
  input wire iss_dag_load_imm,
  input wire iss_sign_ext,
  input wire [3:0] iss_dest_idx,
  input wire iss_agen_use,
  input wire [3:0] iss_use_idx,
  input wire iss_branch,
  input wire iss_branch_cond,
  input wire iss_delayed,
  input wire iss_int_return,
  input wire btb_hit,
  input wire iss_frame_op,
  input wire iss_use_fi6,
  input wire iss_read_fi67,
  input wire loop_term,
  input wire stall,
  input wire issue,
  input wire flush
);
  // ************
  // properties
  // ************
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rst_n);
  property p_issue_gate;
    issue |-> iss_valid && !stall && !flush;
  endproperty
  a_issue_gate: assert property (p_issue_gate) else $error("issue while held");
  property p_issue_free;
    iss_valid && !stall && !flush |-> issue;
  endproperty
  a_issue_free: assert property (p_issue_free) else $error("free instr not issued");
  property p_flush_stall;
    flush |-> !stall;
  endproperty
  a_flush_stall: assert property (p_flush_stall) else $error("stall during flush");
  property p_stall_bound;
    $rose(stall) |-> ##[1:12] !stall;
  endproperty
  a_stall_bound: assert property (p_stall_bound) else $error("stall too long");
  property p_load_use;
    issue && iss_dag_load && !iss_dag_load_cond && !iss_dag_load_imm && !iss_sign_ext
      ##1 iss_valid && iss_agen_use && iss_use_idx == $past(iss_dest_idx)
      |-> stall[*4] ##1 !stall;
  endproperty
  a_load_use: assert property (p_load_use) else $error("load to use stall wrong");
  property p_imm_free;
    issue && iss_dag_load_imm ##1 iss_valid && iss_agen_use |-> !stall;
  endproperty
  a_imm_free: assert property (p_imm_free) else $error("immediate load stalled");
  property p_frame;
    issue && iss_frame_op ##1 iss_valid && (iss_use_fi6 || iss_read_fi67)
      |-> stall[*6] ##1 !stall;
  endproperty
  a_frame: assert property (p_frame) else $error("frame stall wrong");
  property p_br_unc;
    issue && iss_branch && !iss_branch_cond && !iss_delayed && !iss_int_return && !btb_hit
      |=> flush[*6] ##1 !flush;
  endproperty
  a_br_unc: assert property (p_br_unc) else $error("branch flush wrong");
  property p_br_db;
    issue && iss_branch && !iss_branch_cond && iss_delayed && !iss_int_return && !btb_hit
      |=> flush[*4] ##1 !flush;
  endproperty
  a_br_db: assert property (p_br_db) else $error("delayed flush wrong");
  property p_int_ret;
    issue && iss_int_return && !btb_hit |=> flush[*7] ##1 !flush;
  endproperty
  a_int_ret: assert property (p_int_ret) else $error("return flush wrong");
  property p_loop_term;
    loop_term && !flush && !issue |=> flush[*3] ##1 flush[*8] ##1 !flush;
  endproperty
  a_loop_term: assert property (p_loop_term) else $error("loop end flush wrong");
endmodule // cssfc_checker

// *** tb_cssfc_core.sv ***
// self-checking testbench for the core stall and flush control block
`timescale 1ns/1ps
`include "cssfc_consts.vh"
module tb_cssfc_core;
  logic clk_sys = 1'b0;
  logic rst_n = 1'b0;
  logic [7:0] reg_addr = 8'h00;
  logic [31:0] reg_wdata = 32'h0;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic [31:0] reg_rdata;
  logic iss_valid = 1'b0;
  logic [30:0] f = 31'h0; // one bit per instruction attribute
  logic [3:0] idx = 4'h0;
  logic [1:0] n = 2'h0;
  logic loop_term = 1'b0;
  logic stall, issue, flush;
  int bad_count = 0;
  int samples_checked = 0;
  int fc;
  // index and pointer fields are shared by dest and use, so same-register hazards arise
  cssfc_core cssfc_core_inst (
    .clk_sys(clk_sys), .rst_n(rst_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .iss_valid(iss_valid),
    .iss_dag_load(f[0]), .iss_dag_load_cond(f[1]), .iss_dag_load_imm(f[2]),
    .iss_sign_ext(f[3]), .iss_postmod_cond(f[4]), .iss_dest_idx(idx), .iss_cond_set(f[5]),
    .iss_cond_astat(f[6]), .iss_agen_use(f[7]), .iss_ind_jump(f[8]), .iss_use_idx(idx),
    .iss_branch(f[9]), .iss_branch_cond(f[10]), .iss_delayed(f[11]), .iss_int_return(f[12]),
    .iss_sub_return(f[13]), .iss_jump(f[14]), .iss_loop_abort(f[15]), .btb_hit(f[16]),
    .iss_frame_op(f[17]), .iss_use_fi6(f[18]), .iss_read_fi67(f[19]),
    .iss_current_loop_count_write(f[20]), .iss_lce_cond(f[21]), .iss_loop_start(f[22]),
    .iss_cof_unrolled(f[23]), .iss_cof_pos(n), .iss_ret_loop_end(f[24]), .iss_ret_dist(n),
    .iss_target_is_ret(f[25]), .iss_target_is_jump(f[26]), .iss_lstk_mod(f[27]),
    .iss_sysreg_update(f[28]), .iss_second_pe_only(f[29]), .iss_mode_dep(f[30]),
    .loop_term(loop_term), .stall(stall), .issue(issue), .flush(flush));
  // ************
  // tasks
  // ************
  initial begin
    forever #20 clk_sys = ~clk_sys;
  end
  task automatic final_report;
    $display("checked %0d mismatches %0d", samples_checked, bad_count);
    if (bad_count == 0 && samples_checked > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask
  task automatic hang;
    bad_count++;
    final_report;
  endtask
  task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp) begin
      bad_count++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  // every clocked task starts and ends in the time step of a rising edge
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge clk_sys);
    reg_wr <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] exp);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge clk_sys);
    reg_rd <= 1'b0;
    @(negedge clk_sys);
    cmp(reg_rdata, exp);
    @(posedge clk_sys);
  endtask
  // present one instruction, hold it until issued, count the stalled cycles
  task automatic pres(input logic [30:0] fl, output int s);
    int k;
    s = 0;
    f <= fl;
    iss_valid <= 1'b1;
    for (k = 0; k < 40; k++) begin
      @(negedge clk_sys);
      if (stall === 1'b1) s++;
      if (issue === 1'b1) break;
      @(posedge clk_sys);
    end
    if (k == 40) hang;
    @(posedge clk_sys);
  endtask
  // go idle and count the flush cycles that follow
  task automatic drain(output int c);
    int k;
    c = 0;
    iss_valid <= 1'b0;
    f <= 31'h0;
    for (k = 0; k < 40; k++) begin
      @(negedge clk_sys);
      if (flush !== 1'b1) break;
      c++;
    end
    if (k == 40) hang;
    @(posedge clk_sys);
  endtask
  // three instructions back to back; stalls of the last and the flush after it
  task automatic scen(input logic [30:0] x, y, z, input logic [3:0] i, input logic [1:0] m,
      input logic [4:0] es, ef);
    int s, c;
    idx <= i;
    n <= m;
    pres(x, s);
    pres(y, s);
    pres(z, s);
    cmp(32'(s), {27'h0, es});
    drain(c);
    cmp(32'(c), {27'h0, ef});
  endtask
  // ************
  // sequence
  // ************
  initial begin
    repeat (5) @(posedge clk_sys);
    rst_n <= 1'b1;
    @(posedge clk_sys);
    rd(`CSSFC_OFF_CTRL, 32'h0);
    rd(8'h10, 32'h0);
    wr(`CSSFC_OFF_CTRL, 32'h2);
    rd(`CSSFC_OFF_STATUS, 32'h0);
    scen(31'h0, 31'h1, 31'h80, 4'h3, 2'h0, 5'h4, 5'h0);
    scen(31'h0, 31'h0, 31'h200, 4'h0, 2'h0, 5'h0, 5'h6);
    rd(`CSSFC_OFF_STALL_TOTAL, 32'h4);
    rd(`CSSFC_OFF_FLUSH_TOTAL, 32'h6);
    wr(`CSSFC_OFF_CTRL, 32'h2);
    rd(`CSSFC_OFF_STALL_TOTAL, 32'h0);
    rd(`CSSFC_OFF_FLUSH_TOTAL, 32'h0);
    scen(31'h20, 31'h3, 31'h80, 4'h3, 2'h0, 5'h5, 5'h0);
    scen(31'h20, 31'h10, 31'h80, 4'h2, 2'h0, 5'h5, 5'h0);
    scen(31'h0, 31'h5, 31'h80, 4'h3, 2'h0, 5'h0, 5'h0);
    scen(31'h0, 31'h9, 31'h80, 4'h3, 2'h0, 5'h5, 5'h0);
    scen(31'h60, 31'h3, 31'h80, 4'h3, 2'h0, 5'h6, 5'h0);
    scen(31'h0, 31'h1, 31'h100, 4'h4, 2'h0, 5'h4, 5'h0);
    scen(31'h20, 31'h3, 31'h100, 4'h4, 2'h0, 5'h5, 5'h0);
    scen(31'h0, 31'h0, 31'h10200, 4'h0, 2'h0, 5'h0, 5'h6);
    scen(31'h0, 31'h0, 31'ha00, 4'h0, 2'h0, 5'h0, 5'h4);
    scen(31'h0, 31'h20, 31'h600, 4'h0, 2'h0, 5'h0, 5'hb);
    scen(31'h0, 31'h20, 31'he00, 4'h0, 2'h0, 5'h0, 5'h9);
    scen(31'h0, 31'h60, 31'h600, 4'h0, 2'h0, 5'h0, 5'hc);
    scen(31'h0, 31'h0, 31'h1200, 4'h0, 2'h0, 5'h0, 5'h7);
    scen(31'h0, 31'h0, 31'h1a00, 4'h0, 2'h0, 5'h0, 5'h7);
    scen(31'h0, 31'h20000, 31'h40000, 4'h0, 2'h0, 5'h6, 5'h0);
    scen(31'h0, 31'h20000, 31'h80000, 4'h0, 2'h0, 5'h6, 5'h0);
    scen(31'h0, 31'h100000, 31'h200000, 4'h0, 2'h0, 5'h1, 5'h0);
    scen(31'h0, 31'h0, 31'h400000, 4'h0, 2'h0, 5'h0, 5'h0);
    for (int m = 0; m < 4; m++) begin
      scen(31'h0, 31'h0, 31'h800000, 4'h0, 2'(m), 5'(4 - m), 5'h0);
      scen(31'h0, 31'h0, 31'h1002000, 4'h0, 2'(m), 5'(4 - m), 5'h0);
    end
    scen(31'h0, 31'h0, 31'hc000, 4'h0, 2'h0, 5'h4, 5'h0);
    scen(31'h0, 31'h0, 31'h2000000, 4'h0, 2'h0, 5'h3, 5'h0);
    scen(31'h0, 31'h0, 31'h4000000, 4'h0, 2'h0, 5'h1, 5'h0);
    scen(31'h0, 31'h8000000, 31'h2000, 4'h0, 2'h0, 5'h5, 5'h0);
    scen(31'h0, 31'h8000000, 31'h4000, 4'h0, 2'h0, 5'h5, 5'h0);
    scen(31'h10000000, 31'h0, 31'h40000000, 4'h0, 2'h0, 5'h5, 5'h0);
    scen(31'h30000000, 31'h0, 31'h40000000, 4'h0, 2'h0, 5'h0, 5'h0);
    loop_term <= 1'b1;
    @(posedge clk_sys);
    loop_term <= 1'b0;
    drain(fc);
    cmp(32'(fc), 32'hb);
    // loop end while a jump is held: the stall drops as the flush starts
    pres(31'h8000000, fc);
    f <= 31'h4000;
    @(posedge clk_sys);
    loop_term <= 1'b1;
    @(posedge clk_sys);
    loop_term <= 1'b0;
    @(negedge clk_sys);
    cmp({30'h0, flush, stall}, 32'h2);
    @(posedge clk_sys);
    drain(fc);
    cmp(32'(fc), 32'ha);
    // prediction on: a hit costs nothing, a miss still flushes
    wr(`CSSFC_OFF_CTRL, 32'h1);
    rd(`CSSFC_OFF_CTRL, 32'h1);
    scen(31'h0, 31'h0, 31'h10200, 4'h0, 2'h0, 5'h0, 5'h0);
    scen(31'h0, 31'h0, 31'h200, 4'h0, 2'h0, 5'h0, 5'h6);
    final_report;
  end
endmodule // tb_cssfc_core

bind cssfc_core cssfc_checker cssfc_checker_inst (.clk_sys, .rst_n, .iss_valid,
  .iss_dag_load, .iss_dag_load_cond, .iss_dag_load_imm, .iss_sign_ext, .iss_dest_idx,
  .iss_agen_use, .iss_use_idx, .iss_branch, .iss_branch_cond, .iss_delayed,
  .iss_int_return, .btb_hit, .iss_frame_op, .iss_use_fi6, .iss_read_fi67, .loop_term,
  .stall, .issue, .flush);
